// ==== verilog/cbdvm_params.svh ====
// Constants of the charge-balancing voltmeter sequencer
// What this block does
// - One conversion cycle lasts exactly 48000 clocks.
// - Measurement and auto-zero each last 20000 clocks.
// - 4000-clock settling gap between phases, no counting.
// - Flip-flop samples comparator polarity every clock.
// - Complementary outputs steer reference opposing integrator voltage.
// - Zero input gives a 50% toggling stream.
// - Full scale duty is nominally 10% or 90%.
// - Divide-by-four prescaler feeds display counter, max 5000.
// - Display counter is signed, spanning -5000 to +5000.
// - Auto-zero clears counter to -5000, counts inverted stream.
// - Auto-zero shorts modulator inputs to common-mode point.
// - Error-free auto-zero leaves counter near -2500.
// - Measurement continues counting ones, zero input ends zero.
// - Flag positive overrange at a count of 2000.
// - Two hidden guard bits with round-up precede display.
// - Guard logic splits zero into positive and negative.
// - Modulator runs always; only counters are gated.
`ifndef CBDVM_PARAMS_SVH
`define CBDVM_PARAMS_SVH

// Phase lengths in clock periods
`define CBDVM_CYCLE_LEN    16'hBB80
`define CBDVM_AZ_LEN       15'h4E20
`define CBDVM_MEAS_LEN     15'h4E20
`define CBDVM_GAP_LEN      15'h0FA0
`define CBDVM_TICK_ONE     15'h0001
`define CBDVM_TICK_ZERO    15'h0000

// Display counter and guard stage
`define CBDVM_CNT_W        14
`define CBDVM_MAG_W        13
`define CBDVM_FINE_W       16
`define CBDVM_CNT_CLEAR    14'h2C78
`define CBDVM_CNT_ONE      14'h0001
`define CBDVM_CNT_ZERO     14'h0000
`define CBDVM_GUARD_ZERO   2'h0
`define CBDVM_GUARD_ONE    2'h1
`define CBDVM_GUARD_LAST   2'h3
`define CBDVM_ROUND_HALF   16'h0002
`define CBDVM_GUARD_SHIFT  2
`define CBDVM_OVER_POS     14'h07D0
`define CBDVM_OVER_NEG     14'h3830

`endif

// ==== verilog/cbdvm_pkg.sv ====
// Types shared by the charge-balancing voltmeter sequencer
`include "cbdvm_params.svh"

package cbdvm_pkg;

  // Conversion phases in their fixed order
  typedef enum logic [1:0] {
    CBDVM_AUTO_ZERO,
    CBDVM_GAP_AFTER_AZ,
    CBDVM_MEASURE,
    CBDVM_GAP_AFTER_MEAS
  } cbdvm_phase_e;

  // Latched conversion result presented to the display
  typedef struct packed {
    logic                      negative;
    logic [`CBDVM_MAG_W-1:0]   magnitude;
    logic                      overrange;
    logic                      underrange;
    logic                      zero_pos;
    logic                      zero_neg;
  } cbdvm_result_s;

  // Analogue switch and modulator controls
  typedef struct packed {
    logic first_current_switch;
    logic second_current_switch;
    logic input_short;
    logic counters_enabled;
  } cbdvm_switch_s;

  // Whole state of the sequencer
  typedef struct packed {
    cbdvm_phase_e                    phase;
    logic [14:0]                     tick;
    logic [15:0]                     cycle_pos;
    logic                            delta_sigma_modulator;
    logic [1:0]                      guard;
    logic signed [`CBDVM_CNT_W-1:0]  count;
    cbdvm_result_s                   result;
    logic                            result_valid;
    logic                            conversion_start;
  } cbdvm_state_s;

endpackage : cbdvm_pkg

// ==== verilog/cbdvm_sequencer.sv ====
// Digital sequencer, modulator flip-flop and counters of a charge-balancing voltmeter
`timescale 1ns/1ps
`default_nettype none
`include "cbdvm_params.svh"

module cbdvm_sequencer (
  input  wire logic                    clk_sys_i,
  input  wire logic                    sys_rst_i,
  input  wire logic                    comparator_i,
  output cbdvm_pkg::cbdvm_switch_s     switch_o,
  output cbdvm_pkg::cbdvm_phase_e      phase_o,
  output cbdvm_pkg::cbdvm_result_s     result_o,
  output logic                         result_valid_o,
  output logic                         conversion_start_o,
  output logic signed [13:0]           live_count_o
);
  import cbdvm_pkg::*;

  // Length of a phase, in clock periods
  function automatic logic [14:0] phase_len(input cbdvm_phase_e ph);
    logic [14:0] len;
    len = `CBDVM_GAP_LEN;
    unique case (ph)
      CBDVM_AUTO_ZERO:      len = `CBDVM_AZ_LEN;
      CBDVM_MEASURE:        len = `CBDVM_MEAS_LEN;
      CBDVM_GAP_AFTER_AZ:   len = `CBDVM_GAP_LEN;
      CBDVM_GAP_AFTER_MEAS: len = `CBDVM_GAP_LEN;
    endcase
    return len;
  endfunction : phase_len

  // Successor of a phase; the order never changes
  function automatic cbdvm_phase_e phase_next(input cbdvm_phase_e ph);
    cbdvm_phase_e nx;
    nx = CBDVM_AUTO_ZERO;
    unique case (ph)
      CBDVM_AUTO_ZERO:      nx = CBDVM_GAP_AFTER_AZ;
      CBDVM_GAP_AFTER_AZ:   nx = CBDVM_MEASURE;
      CBDVM_MEASURE:        nx = CBDVM_GAP_AFTER_MEAS;
      CBDVM_GAP_AFTER_MEAS: nx = CBDVM_AUTO_ZERO;
    endcase
    return nx;
  endfunction : phase_next

  // Inputs are shorted from the gap before auto-zero onward, so they settle first
  function automatic logic shorted_in(input cbdvm_phase_e ph);
    return (ph == CBDVM_AUTO_ZERO) || (ph == CBDVM_GAP_AFTER_MEAS);
  endfunction : shorted_in

  // Build the displayed result from counter and guard bits
  function automatic cbdvm_result_s make_result(
    input logic signed [`CBDVM_CNT_W-1:0] cnt,
    input logic        [1:0]              grd
  );
    cbdvm_result_s                   r;
    logic signed [`CBDVM_FINE_W-1:0] fine;
    logic signed [`CBDVM_FINE_W-1:0] rounded;
    logic signed [`CBDVM_CNT_W-1:0]  disp;
    logic        [`CBDVM_CNT_W-1:0]  mag;
    r       = '0;
    // Fine count has four steps per displayed digit
    fine    = {cnt, grd};
    // Half a digit added before truncation rounds up at the guard bits
    rounded = fine + `CBDVM_ROUND_HALF;
    disp    = rounded[`CBDVM_FINE_W-1:`CBDVM_GUARD_SHIFT];
    // Sign comes from the fine count, so a small negative rounds to minus zero
    r.negative = fine[`CBDVM_FINE_W-1];
    r.zero_pos = (disp == `CBDVM_CNT_ZERO) && !fine[`CBDVM_FINE_W-1];
    r.zero_neg = (disp == `CBDVM_CNT_ZERO) && fine[`CBDVM_FINE_W-1];
    // Sign flag plus magnitude for the display
    mag = disp[`CBDVM_CNT_W-1] ? (`CBDVM_CNT_W)'(-disp) : disp;
    r.magnitude  = mag[`CBDVM_MAG_W-1:0];
    // Positive overrange at 2000, which is 90% duty at full scale
    r.overrange  = (disp >= $signed(`CBDVM_OVER_POS));
    // Negative limit mirrors it at 10% duty
    r.underrange = (disp <= $signed(`CBDVM_OVER_NEG));
    return r;
  endfunction : make_result

  cbdvm_state_s state_q;
  cbdvm_state_s state_d;

  // Next-state logic
  always_comb begin
    logic                           last_tick;
    logic                           count_event;
    logic        [1:0]              guard_nx;
    logic signed [`CBDVM_CNT_W-1:0] count_nx;
    last_tick   = 1'b0;
    count_event = 1'b0;
    guard_nx    = state_q.guard;
    count_nx    = state_q.count;
    state_d     = state_q;

    // Modulator flip-flop samples comparator every clock, in every phase
    state_d.delta_sigma_modulator = comparator_i;

    // Defaults for pulses
    state_d.result_valid     = 1'b0;
    state_d.conversion_start = 1'b0;

    // Phase timing; the four phases sum to one 48000-clock cycle
    last_tick = (state_q.tick == phase_len(state_q.phase) - `CBDVM_TICK_ONE);
    if (last_tick) begin
      state_d.tick  = `CBDVM_TICK_ZERO;
      state_d.phase = phase_next(state_q.phase);
    end else begin
      state_d.tick = state_q.tick + `CBDVM_TICK_ONE;
    end

    // Position in the whole cycle, wraps with the phase sequence
    if (last_tick && (state_q.phase == CBDVM_GAP_AFTER_MEAS)) begin
      state_d.cycle_pos = '0;
    end else begin
      state_d.cycle_pos = state_q.cycle_pos + 16'h0001;
    end

    // Counting events: inverted stream in auto-zero, ones in measurement
    unique case (state_q.phase)
      CBDVM_AUTO_ZERO:      count_event = !state_q.delta_sigma_modulator;
      CBDVM_MEASURE:        count_event = state_q.delta_sigma_modulator;
      CBDVM_GAP_AFTER_AZ:   count_event = 1'b0;
      CBDVM_GAP_AFTER_MEAS: count_event = 1'b0;
    endcase

    // Divide-by-four guard stage, carry advances the display counter
    if (count_event) begin
      guard_nx = state_q.guard + `CBDVM_GUARD_ONE;
      if (state_q.guard == `CBDVM_GUARD_LAST) begin
        // At most 20000 events per phase, so 5000 carries; range stays inside +-5000
        count_nx = state_q.count + `CBDVM_CNT_ONE;
      end
    end

    // Measurement continues from the auto-zero result without any clear
    state_d.guard = guard_nx;
    state_d.count = count_nx;

    // Entering auto-zero clears counter to -5000 and the guard bits
    if (last_tick && (state_q.phase == CBDVM_GAP_AFTER_MEAS)) begin
      state_d.guard            = `CBDVM_GUARD_ZERO;
      state_d.count            = `CBDVM_CNT_CLEAR;
      state_d.conversion_start = 1'b1;
    end

    // Zero-error auto-zero counts 2500 and leaves the preset near -2500
    // No correction is applied: the offset simply lives in this preset
    if (last_tick && (state_q.phase == CBDVM_AUTO_ZERO)) begin
      state_d.count = count_nx;
    end

    // Latch the final count, including the last clock's event
    if (last_tick && (state_q.phase == CBDVM_MEASURE)) begin
      state_d.result       = make_result(count_nx, guard_nx);
      state_d.result_valid = 1'b1;
    end

    // Synchronous reset starts a fresh cycle at auto-zero
    if (sys_rst_i) begin
      state_d                  = '0;
      state_d.phase            = CBDVM_AUTO_ZERO;
      state_d.count            = `CBDVM_CNT_CLEAR;
      state_d.guard            = `CBDVM_GUARD_ZERO;
      state_d.result.zero_pos  = 1'b1;
      state_d.conversion_start = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_sys_i) begin
    state_q <= state_d;
  end

  // Complementary switch drive: the flop state picks the current switch
  // that removes charge of the polarity the comparator just saw
  always_comb begin
    switch_o.first_current_switch  = state_q.delta_sigma_modulator;
    switch_o.second_current_switch = !state_q.delta_sigma_modulator;
    switch_o.input_short           = shorted_in(state_q.phase);
    switch_o.counters_enabled      = (state_q.phase == CBDVM_AUTO_ZERO) ||
                                     (state_q.phase == CBDVM_MEASURE);
  end

  // Result and status outputs come straight from state flops
  assign phase_o            = state_q.phase;
  assign result_o           = state_q.result;
  assign result_valid_o     = state_q.result_valid;
  assign conversion_start_o = state_q.conversion_start;
  assign live_count_o       = state_q.count;

endmodule : cbdvm_sequencer
`default_nettype wire

// ==== verification/cbdvm_sequencer_checker.sv ====
// Port-level assertions for the voltmeter sequencer
`timescale 1ns/1ps
`default_nettype none
`include "cbdvm_params.svh"
module cbdvm_sequencer_checker (
  input wire logic                     clk_sys_i,
  input wire logic                     sys_rst_i,
  input wire logic                     comparator_i,
  input wire cbdvm_pkg::cbdvm_switch_s switch_o,
  input wire cbdvm_pkg::cbdvm_phase_e  phase_o,
  input wire cbdvm_pkg::cbdvm_result_s result_o,
  input wire logic                     result_valid_o,
  input wire logic                     conversion_start_o,
  input wire logic signed [13:0]       live_count_o
);
  import cbdvm_pkg::*;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  cbdvm_phase_e last_q;
  logic [15:0]  run_q;
  logic [16:0]  cyc_q;
  // Run length of the previous phase and cycles since a conversion began; too long to unroll
  always_ff @(posedge clk_sys_i) begin
    last_q <= phase_o;
    run_q  <= sys_rst_i ? 16'h0000 : (phase_o != last_q) ? 16'h0001 : run_q + 16'h0001;
    cyc_q  <= sys_rst_i ? 17'h00000 : conversion_start_o ? 17'h00001 : cyc_q + 17'h00001;
  end
  property p_flop; !$past(sys_rst_i) |-> switch_o.first_current_switch == $past(comparator_i);
  endproperty
  a_flop: assert property (p_flop) else $error("flop misses comparator");
  property p_compl; switch_o.second_current_switch != switch_o.first_current_switch; endproperty
  a_compl: assert property (p_compl) else $error("switches not complementary");
  property p_len; (phase_o != last_q) |-> run_q == ((last_q == CBDVM_AUTO_ZERO ||
    last_q == CBDVM_MEASURE) ? `CBDVM_AZ_LEN : `CBDVM_GAP_LEN); endproperty
  a_len: assert property (p_len) else $error("phase length wrong");
  property p_order; (phase_o != last_q) |-> phase_o == cbdvm_phase_e'(last_q + 2'h1); endproperty
  a_order: assert property (p_order) else $error("phase order wrong");
  property p_cycle; (cyc_q != 17'h00000) |-> conversion_start_o == (cyc_q == `CBDVM_CYCLE_LEN);
  endproperty
  a_cycle: assert property (p_cycle) else $error("cycle length wrong");
  property p_gap; phase_o == CBDVM_GAP_AFTER_AZ |=> $stable(live_count_o); endproperty
  a_gap: assert property (p_gap) else $error("count moved in gap");
  property p_clear; conversion_start_o |-> live_count_o == -14'sd5000; endproperty
  a_clear: assert property (p_clear) else $error("count not cleared");
  property p_short; switch_o.input_short == (phase_o inside {CBDVM_AUTO_ZERO,
    CBDVM_GAP_AFTER_MEAS}); endproperty
  a_short: assert property (p_short) else $error("input short wrong");
  property p_valid; result_valid_o |-> phase_o == CBDVM_GAP_AFTER_MEAS &&
    $past(phase_o) == CBDVM_MEASURE; endproperty
  a_valid: assert property (p_valid) else $error("result at wrong time");
  property p_hold; !result_valid_o |-> $stable(result_o); endproperty
  a_hold: assert property (p_hold) else $error("result changed");
  property p_zero; result_o.zero_pos |-> !result_o.negative && result_o.magnitude == 13'h0000;
  endproperty
  a_zero: assert property (p_zero) else $error("positive zero wrong");
endmodule : cbdvm_sequencer_checker
bind cbdvm_sequencer cbdvm_sequencer_checker u_chk (.clk_sys_i(clk_sys_i),
  .sys_rst_i(sys_rst_i), .comparator_i(comparator_i), .switch_o(switch_o), .phase_o(phase_o),
  .result_o(result_o), .result_valid_o(result_valid_o),
  .conversion_start_o(conversion_start_o), .live_count_o(live_count_o));
`default_nettype wire

// ==== verification/cbdvm_comparator_model.sv ====
// Behavioural comparator and charge-balance integrator on the far side
`timescale 1ns/1ps
`default_nettype none
module cbdvm_comparator_model (
  input  wire logic clk_sys_i,
  input  wire logic sys_rst_i,
  input  wire logic first_current_switch,
  input  wire logic input_short,
  input  var  int   level,
  output logic      comparator_o
);
  int acc = 0;
  // Reference charge opposes the flop; shorted inputs carry no signal
  always @(posedge clk_sys_i) begin
    #1;
    acc = sys_rst_i ? 0 : acc + (input_short ? 0 : level) + (first_current_switch ? -1000 : 1000);
  end
  assign comparator_o = acc > 0;
endmodule : cbdvm_comparator_model
`default_nettype wire

// ==== verification/tb_top.sv ====
// Closed-loop bench: sequencer against a comparator model over two conversions
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import cbdvm_pkg::*;
  logic               clk_sys_i = 1'b0;
  logic               sys_rst_i = 1'b1;
  logic               comparator_i;
  cbdvm_switch_s      switch_o;
  cbdvm_phase_e       phase_o;
  cbdvm_result_s      result_o;
  logic               result_valid_o;
  logic               conversion_start_o;
  logic signed [13:0] live_count_o;
  logic               cq = 1'b0;
  int errors = 0;
  int checks = 0;
  int k = 0;
  int m = 0;
  int fine = 0;
  int level = 0;
  int cycles = 0;
  always #2.5 clk_sys_i = ~clk_sys_i;
  cbdvm_sequencer dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .comparator_i(comparator_i),
    .switch_o(switch_o), .phase_o(phase_o), .result_o(result_o), .result_valid_o(result_valid_o),
    .conversion_start_o(conversion_start_o), .live_count_o(live_count_o));
  cbdvm_comparator_model model (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .first_current_switch(switch_o.first_current_switch), .input_short(switch_o.input_short),
    .level(level), .comparator_o(comparator_i));
  function automatic cbdvm_phase_e exp_phase(input int p);
    return p < 20000 ? CBDVM_AUTO_ZERO : p < 24000 ? CBDVM_GAP_AFTER_AZ :
      p < 44000 ? CBDVM_MEASURE : CBDVM_GAP_AFTER_MEAS;
  endfunction : exp_phase
  // Rounded display value from the fine count with two guard bits
  function automatic cbdvm_result_s exp_result(input int f);
    int d;
    cbdvm_result_s r;
    d = (f + 2) >>> 2;
    r.negative   = f < 0;
    r.magnitude  = 13'(d < 0 ? -d : d);
    r.overrange  = d >= 2000;
    r.underrange = d <= -2000;
    r.zero_pos   = d == 0 && f >= 0;
    r.zero_neg   = d == 0 && f < 0;
    return r;
  endfunction : exp_result
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run
  // Cycle index since reset release and the flop value the design should hold
  always @(posedge clk_sys_i) begin
    k      <= sys_rst_i ? 0 : k + 1;
    cq     <= sys_rst_i ? 1'b0 : comparator_i;
    cycles <= cycles + 1;
    if (cycles == 97000) begin
      errors++;
      complete_run();
    end
  end
  // Mid-cycle comparison, so the registered outputs have settled
  always @(negedge clk_sys_i) begin
    if (!sys_rst_i) begin
      m = k % 48000;
      if (m == 0)
        fine = -20000;
      check(phase_o, exp_phase(m));
      check(conversion_start_o, m == 0);
      check(switch_o.first_current_switch, cq);
      check(switch_o.second_current_switch, !cq);
      check(switch_o.input_short, m < 20000 || m >= 44000);
      check(switch_o.counters_enabled, m < 20000 || (m >= 24000 && m < 44000));
      check(live_count_o, 14'(fine >>> 2));
      check(result_valid_o, m == 44000);
      if (m == 44000)
        check(result_o, exp_result(fine));
      if (m == 20000 && level == 0)
        check(live_count_o, 14'sh363C);
      if ((m < 20000 && !cq) || (m >= 24000 && m < 44000 && cq))
        fine++;
      // Second conversion near plus full scale, where the display overranges
      if (m == 47999)
        level = 800 + $urandom_range(150);
    end
  end
  initial begin
    void'($urandom(84));
    repeat (16) @(posedge clk_sys_i);
    #1 sys_rst_i = 1'b0;
    repeat (96002) @(posedge clk_sys_i);
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
